// File: hdl/line_ctl_two.sv
// line control register two with its interrupt status and mask registers
// assumes an Avalon-MM master on mclk and asynchronous line-side pins
//
// Notes on behaviour
// - eight fields from bit 7 down: cal clear, cal start, cal off, ring hi.
// - clear_cal_data at one discards stored calibration data.
// - writing one to manual_cal_start begins a manual calibration.
// - auto_cal_disable at one suppresses automatic calibration.
// - threshold pair lo,hi selects band: 00 low, 10 mid, 11 high.
// - tone_detect_en keeps the line off-hook through supply disruptions.
// - with tone_detect_en zero, tone_detected_flag records nothing.
// - writing tone_detect_en zero clears tone_detected_flag; flag read-only.
// - receive pin below ground sets rx_overload_flag.
// - writing zero to rx_overload_flag clears it and irq bit 6.
`include "line_ctl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module line_ctl_two (
    input wire logic mclk, // 250 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall, high while busy
    input wire logic rx_below_ground, // pin: receive input below ground
    input wire logic supply_disrupt, // pin: line-side supply disturbed
    input wire logic ring_threshold_sel_lo, // low threshold select bit
    input wire logic offhook_req, // off-hook request from line logic
    output logic cal_clear, // discard calibration data
    output logic cal_start, // one-cycle manual calibration start
    output logic auto_cal_en, // automatic calibration allowed
    output line_ctl_pkg::ring_band_e ring_band, // ring threshold band
    output logic overload_protect, // overload protection enabled
    output logic line_offhook, // line held off-hook
    output logic irq // level interrupt
);

    line_ctl_pkg::av_req_s req;
    line_ctl_pkg::bus_state_e bus_state_r;
    line_ctl_pkg::bus_state_e bus_state_nxt;
    line_ctl_pkg::line_ctl2_s wr_fields;
    line_ctl_pkg::line_ctl2_s lc2_view;

    logic [1:0] pins_sync;
    logic rov_level;
    logic disrupt_level;

    // software-held fields of line_control_two
    logic clear_cal_data_r;
    logic manual_cal_start_r;
    logic auto_cal_disable_r;
    logic ring_threshold_sel_hi_r;
    logic overload_protect_en_r;
    logic tone_detect_en_r;

    logic [7:0] irq_mask_r;
    logic [7:0] irq_stat;
    logic [7:0] irq_stat_clr;
    logic [7:0] irq_stat_set;

    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [1:0] flag_q;

    logic [5:0] index;
    logic hit_lc2;
    logic hit_stat;
    logic hit_mask;
    logic wr_commit;
    logic lane0;
    logic tone_event;

    assign req = '{read: avs_read, write: avs_write,
                   address: avs_address, byteenable: avs_byteenable,
                   writedata: avs_writedata};
    assign index = req.address[7:2];
    assign hit_lc2 = (index == `LC2_IDX);
    assign hit_stat = (index == `IRQ_STAT_IDX);
    assign hit_mask = (index == `IRQ_MASK_IDX);
    assign lane0 = req.byteenable[0];
    assign wr_fields = line_ctl_pkg::line_ctl2_s'(req.writedata[7:0]);

    // a write lands at the edge where waitrequest is sampled low
    assign wr_commit = (bus_state_r == line_ctl_pkg::BUS_ACK) &&
                       req.write && lane0;

    // line-side pins cross into mclk before anything looks at them
    sync2 #(
        .W(2)
    ) u_pin_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din({rx_below_ground, supply_disrupt}),
        .dout(pins_sync)
    );

    assign rov_level = pins_sync[1];
    assign disrupt_level = pins_sync[0];

    // detection only while enabled, so a disabled detector records nothing
    assign tone_event = tone_detect_en_r && disrupt_level;

    // flag_q[1] is rx_overload_flag, flag_q[0] is tone_detected_flag
    always_comb
    begin
        flag_set = {rov_level, tone_event};
        flag_clr = 2'h0;
        if (wr_commit && hit_lc2)
        begin
            // writing one leaves the overload flag alone
            flag_clr[1] = !wr_fields.rx_overload_flag;
            // disabling detection wipes the detected flag
            flag_clr[0] = !wr_fields.tone_detect_en;
        end
    end

    sticky_flag #(
        .W(2)
    ) u_line_flags (
        .mclk(mclk),
        .rstn(rstn),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    // interrupt status: write one to clear, plus the overload side clear
    always_comb
    begin
        irq_stat_set = 8'h00;
        irq_stat_set[`IRQ_ROV_BIT] = rov_level;
        irq_stat_set[`IRQ_TONE_BIT] = tone_event;
        irq_stat_clr = 8'h00;
        if (wr_commit && hit_stat)
        begin
            irq_stat_clr = req.writedata[7:0];
        end
        if (flag_clr[1])
        begin
            irq_stat_clr[`IRQ_ROV_BIT] = 1'b1;
        end
    end

    sticky_flag #(
        .W(8)
    ) u_irq_stat (
        .mclk(mclk),
        .rstn(rstn),
        .set(irq_stat_set),
        .clr(irq_stat_clr),
        .q(irq_stat)
    );

    // control fields; the flag bits of a write are handled above
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            clear_cal_data_r <= 1'b0;
            manual_cal_start_r <= 1'b0;
            auto_cal_disable_r <= 1'b0;
            ring_threshold_sel_hi_r <= 1'b0;
            overload_protect_en_r <= 1'b0;
            tone_detect_en_r <= 1'b0;
        end
        else if (wr_commit && hit_lc2)
        begin
            clear_cal_data_r <= wr_fields.clear_cal_data;
            manual_cal_start_r <= wr_fields.manual_cal_start;
            auto_cal_disable_r <= wr_fields.auto_cal_disable;
            // reserved band code is stored as written, software avoids it
            ring_threshold_sel_hi_r <= wr_fields.ring_threshold_sel_hi;
            overload_protect_en_r <= wr_fields.overload_protect_en;
            tone_detect_en_r <= wr_fields.tone_detect_en;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_mask_r <= `IRQ_MASK_RESET;
        end
        else if (wr_commit && hit_mask)
        begin
            irq_mask_r <= req.writedata[7:0];
        end
    end

    // readback view of line_control_two, most significant field first
    always_comb
    begin
        lc2_view.clear_cal_data = clear_cal_data_r;
        lc2_view.manual_cal_start = manual_cal_start_r;
        lc2_view.auto_cal_disable = auto_cal_disable_r;
        lc2_view.ring_threshold_sel_hi = ring_threshold_sel_hi_r;
        lc2_view.overload_protect_en = overload_protect_en_r;
        lc2_view.tone_detect_en = tone_detect_en_r;
        lc2_view.rx_overload_flag = flag_q[1];
        lc2_view.tone_detected_flag = flag_q[0];
    end

    // bus slave: one wait cycle, then one recovery cycle
    always_comb
    begin
        case (bus_state_r)
            line_ctl_pkg::BUS_IDLE:
            begin
                if (req.read || req.write)
                begin
                    bus_state_nxt = line_ctl_pkg::BUS_ACK;
                end
                else
                begin
                    bus_state_nxt = line_ctl_pkg::BUS_IDLE;
                end
            end
            line_ctl_pkg::BUS_ACK:
            begin
                bus_state_nxt = line_ctl_pkg::BUS_DONE;
            end
            line_ctl_pkg::BUS_DONE:
            begin
                bus_state_nxt = line_ctl_pkg::BUS_IDLE;
            end
            default:
            begin
                bus_state_nxt = line_ctl_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_state_r <= line_ctl_pkg::BUS_IDLE;
        end
        else
        begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // waitrequest drops only in the acknowledge state
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= (bus_state_nxt != line_ctl_pkg::BUS_ACK);
        end
    end

    // read data is captured as the wait ends; unmapped reads give zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (bus_state_r == line_ctl_pkg::BUS_IDLE && req.read)
        begin
            if (hit_lc2)
            begin
                avs_readdata <= {24'h00_0000, lc2_view};
            end
            else if (hit_stat)
            begin
                avs_readdata <= {24'h00_0000, irq_stat};
            end
            else if (hit_mask)
            begin
                avs_readdata <= {24'h00_0000, irq_mask_r};
            end
            else
            begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // calibration controls
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cal_clear <= 1'b0;
            cal_start <= 1'b0;
            auto_cal_en <= 1'b1;
        end
        else
        begin
            cal_clear <= clear_cal_data_r;
            // a start is a fresh request each time a one is written
            cal_start <= wr_commit && hit_lc2 &&
                         wr_fields.manual_cal_start;
            auto_cal_en <= !auto_cal_disable_r;
        end
    end

    // ring threshold band from the pair {sel_lo, sel_hi}
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ring_band <= line_ctl_pkg::BAND_LOW;
        end
        else
        begin
            case ({ring_threshold_sel_lo, ring_threshold_sel_hi_r})
                2'h0: ring_band <= line_ctl_pkg::BAND_LOW;
                2'h2: ring_band <= line_ctl_pkg::BAND_MID;
                2'h3: ring_band <= line_ctl_pkg::BAND_HIGH;
                default: ring_band <= line_ctl_pkg::BAND_RSVD;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            overload_protect <= 1'b0;
        end
        else
        begin
            overload_protect <= overload_protect_en_r;
        end
    end

    // hold the hook through a disruption only while detection is on;
    // an on-hook line is never pulled off-hook by a disruption
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            line_offhook <= 1'b0;
        end
        else
        begin
            line_offhook <= offhook_req ||
                            (line_offhook && tone_detect_en_r &&
                             disrupt_level);
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat & irq_mask_r);
        end
    end

endmodule : line_ctl_two

`default_nettype wire

// File: hdl/line_ctl_defines.svh
// register map, reset values and field positions of the line control block
// assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef LINE_CTL_DEFINES_SVH
`define LINE_CTL_DEFINES_SVH

// register indices; byte address is four times the index
`define LC2_IDX 6'h11
`define IRQ_STAT_IDX 6'h04
`define IRQ_MASK_IDX 6'h05

// reset values
`define LC2_RESET 8'h00
`define IRQ_STAT_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

// field positions inside line_control_two
`define LC2_ROV_BIT 1
`define LC2_TONE_EN_BIT 2

// field positions inside the interrupt status and mask registers
`define IRQ_ROV_BIT 6
`define IRQ_TONE_BIT 0

// cycles between the bus answer and the next request being accepted
`define BUS_RECOVER_CYCLES 1

`endif

// File: hdl/line_ctl_pkg.sv
// types shared by the line control register block
// assumes the defines header supplies all numeric constants
package line_ctl_pkg;

    // one control and status byte, most significant field first
    typedef struct packed {
        logic clear_cal_data;
        logic manual_cal_start;
        logic auto_cal_disable;
        logic ring_threshold_sel_hi;
        logic overload_protect_en;
        logic tone_detect_en;
        logic rx_overload_flag;
        logic tone_detected_flag;
    } line_ctl2_s;

    // one Avalon-MM request as seen by the slave
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } av_req_s;

    // ring detection threshold band, encoded as {sel_hi, sel_lo}
    typedef enum logic [1:0] {
        BAND_LOW = 2'h0,
        BAND_MID = 2'h1,
        BAND_HIGH = 2'h3,
        BAND_RSVD = 2'h2
    } ring_band_e;

    // bus slave states, gray coded from idle to done; the return to idle flips both bits
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK = 2'h1,
        BUS_DONE = 2'h3
    } bus_state_e;

endpackage : line_ctl_pkg

// File: hdl/sync2.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    input wire logic mclk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] din, // asynchronous levels
    output logic [W-1:0] dout // synchronised levels
);

    logic [W-1:0] meta_r;

    // the first stage feeds only the second stage
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : sync2

`default_nettype wire

// File: hdl/sticky_flag.sv
// group of sticky status bits: set by hardware, cleared by software
// assumes set and clear are single-clock-domain strobes or levels
`timescale 1ns/10ps
`default_nettype none

module sticky_flag #(
    parameter int W = 1
) (
    input wire logic mclk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] set, // hardware event
    input wire logic [W-1:0] clr, // software clear
    output logic [W-1:0] q // flag state
);

    // set wins over clear so an event in the clearing cycle is kept
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= set | (q & ~clr);
        end
    end

endmodule : sticky_flag

`default_nettype wire

// File: sim/line_ctl_two_properties.sv
// port-level checker for the line control register block
// assumes a bind to line_ctl_two and a single mclk domain
`include "line_ctl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module line_ctl_two_props (
    input wire logic mclk, // clock
    input wire logic rstn, // reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic rx_below_ground, // pin
    input wire logic supply_disrupt, // pin
    input wire logic ring_threshold_sel_lo, // low select
    input wire logic offhook_req, // off-hook wish
    input wire logic cal_clear, // cal clear
    input wire logic cal_start, // cal start
    input wire logic auto_cal_en, // auto cal
    input wire line_ctl_pkg::ring_band_e ring_band, // band
    input wire logic overload_protect, // protection
    input wire logic line_offhook, // off-hook
    input wire logic irq // interrupt
);
    logic wr_lc2;
    // a write to the control byte takes effect at the edge seen here
    assign wr_lc2 = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address[7:2] == `LC2_IDX;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_wait_one_cycle: assert property ($fell(avs_waitrequest)
        |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_request_answered: assert property ((avs_read || avs_write)
        |-> ##[0:3] !avs_waitrequest) else $error("request not answered");
    a_upper_zero: assert property (!avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0) else $error("read data upper bits");
    a_cal_clear_follow: assert property (wr_lc2
        |-> ##2 cal_clear == $past(avs_writedata[7], 2))
        else $error("cal_clear");
    a_cal_start_pulse: assert property (wr_lc2 && avs_writedata[6]
        |-> ##[1:2] cal_start) else $error("cal_start missing");
    a_cal_start_once: assert property (cal_start |=> !cal_start)
        else $error("cal_start longer than one cycle");
    a_auto_cal_follow: assert property (wr_lc2
        |-> ##2 auto_cal_en == !$past(avs_writedata[5], 2))
        else $error("auto");
    a_protect_follow: assert property (wr_lc2
        |-> ##2 overload_protect == $past(avs_writedata[3], 2))
        else $error("overload_protect");
    a_band_high: assert property (wr_lc2
        |-> ##2 ring_band[1] == $past(avs_writedata[4], 2))
        else $error("band hi");
    a_band_low: assert property ($stable(ring_threshold_sel_lo)[*3]
        |-> ring_band[0] == ring_threshold_sel_lo) else $error("band lo");
    a_offhook_req: assert property (offhook_req |=> line_offhook)
        else $error("line_offhook missing");
    a_offhook_drop: assert property (
        (!offhook_req && !supply_disrupt)[*4] |=> !line_offhook)
        else $error("line_offhook stuck");

    c_cal_start: cover property (wr_lc2 && avs_writedata[6]);
    c_irq: cover property ($rose(irq));
    c_hold: cover property (line_offhook && !offhook_req);
endmodule : line_ctl_two_props

bind line_ctl_two line_ctl_two_props line_ctl_two_props_inst (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_below_ground(rx_below_ground), .supply_disrupt(supply_disrupt),
    .ring_threshold_sel_lo(ring_threshold_sel_lo), .offhook_req(offhook_req),
    .cal_clear(cal_clear), .cal_start(cal_start), .auto_cal_en(auto_cal_en),
    .ring_band(ring_band), .overload_protect(overload_protect),
    .line_offhook(line_offhook), .irq(irq)
);

`default_nettype wire

// File: sim/tb.sv
// self-checking bench for line_ctl_two over its Avalon-MM port
// assumes the checker is bound separately; pins are driven directly
`include "line_ctl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [7:0] lc2_addr = {`LC2_IDX, 2'b00};
    localparam logic [7:0] stat_addr = {`IRQ_STAT_IDX, 2'b00};
    localparam logic [7:0] mask_addr = {`IRQ_MASK_IDX, 2'b00};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0;
    logic rx_below_ground = 1'b0;
    logic supply_disrupt = 1'b0;
    logic ring_threshold_sel_lo = 1'b0;
    logic offhook_req = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, cal_clear, cal_start, auto_cal_en;
    logic overload_protect, line_offhook, irq;
    logic [31:0] q;
    line_ctl_pkg::ring_band_e ring_band;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int pulses = 0;

    line_ctl_two line_ctl_two_inst (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_below_ground(rx_below_ground),
        .supply_disrupt(supply_disrupt),
        .ring_threshold_sel_lo(ring_threshold_sel_lo),
        .offhook_req(offhook_req), .cal_clear(cal_clear),
        .cal_start(cal_start), .auto_cal_en(auto_cal_en),
        .ring_band(ring_band), .overload_protect(overload_protect),
        .line_offhook(line_offhook), .irq(irq));

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    task end_sim;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // counts start pulses and cuts a hang short well past the expected run
    always @(posedge mclk)
    begin
        cycles++;
        if (cal_start === 1'b1)
            pulses++;
        if (cycles == 3000)
        begin
            errors++;
            end_sim();
        end
    end

    task check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // holds the request until waitrequest is sampled low, then releases it
    task bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge mclk);
        // no fixed wait count: only the cycle ceiling ends a lost answer
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge mclk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'hF);
    endtask : wr

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b1, a, 8'h00, 4'hF);
        check(nm, q, exp);
    endtask : rd_chk

    task rx_pulse;
        rx_below_ground <= 1'b1;
        repeat (3) @(posedge mclk);
        rx_below_ground <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : rx_pulse

    initial
    begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk("lc2 reset", lc2_addr, 32'h0);
        rd_chk("status reset", stat_addr, 32'h0);
        rd_chk("mask reset", mask_addr, 32'h0);
        check("auto_cal_en reset", auto_cal_en, 32'h1);
        $display("test reset done");

        wr(lc2_addr, 8'hEB);
        repeat (3) @(posedge mclk);
        check("cal_clear", cal_clear, 32'h1);
        check("auto_cal_en", auto_cal_en, 32'h0);
        check("overload_protect", overload_protect, 32'h1);
        check("start pulses", pulses, 32'h1);
        rd_chk("lc2 readback", lc2_addr, 32'hE8);
        wr(lc2_addr, 8'h40);
        repeat (3) @(posedge mclk);
        check("cal_clear off", cal_clear, 32'h0);
        check("start pulses", pulses, 32'h2);
        check("auto_cal_en on", auto_cal_en, 32'h1);
        $display("test control fields done");

        for (int i = 0; i < 3; i++)
        begin
            ring_threshold_sel_lo <= (i > 0);
            wr(lc2_addr, (i == 2) ? 8'h10 : 8'h00);
            repeat (3) @(posedge mclk);
            check("ring_band", ring_band, {30'h0, i == 2, i > 0});
        end
        $display("test ring bands done");

        wr(mask_addr, 8'h41);
        rx_pulse();
        rd_chk("rx flag set", lc2_addr, 32'h12);
        rd_chk("rx status", stat_addr, 32'h40);
        check("irq raised", irq, 32'h1);
        wr(lc2_addr, 8'h02);
        rd_chk("rx flag kept", lc2_addr, 32'h02);
        wr(lc2_addr, 8'h00);
        rd_chk("rx flag cleared", lc2_addr, 32'h0);
        rd_chk("rx status cleared", stat_addr, 32'h0);
        repeat (2) @(posedge mclk);
        check("irq cleared", irq, 32'h0);
        wr(mask_addr, 8'h00);
        rx_pulse();
        check("irq masked", irq, 32'h0);
        bus(1'b0, mask_addr, 8'h41, 4'h0);
        rd_chk("mask lane off", mask_addr, 32'h0);
        wr(stat_addr, 8'h40);
        rd_chk("status w1c", stat_addr, 32'h0);
        wr(lc2_addr, 8'h00);
        rd_chk("unmapped", 8'hFC, 32'h0);
        $display("test overload done");

        supply_disrupt <= 1'b1;
        repeat (6) @(posedge mclk);
        supply_disrupt <= 1'b0;
        rd_chk("tone off", lc2_addr, 32'h0);
        wr(lc2_addr, 8'h04);
        offhook_req <= 1'b1;
        supply_disrupt <= 1'b1;
        repeat (5) @(posedge mclk);
        offhook_req <= 1'b0;
        repeat (3) @(posedge mclk);
        check("offhook held", line_offhook, 32'h1);
        rd_chk("tone flag", lc2_addr, 32'h05);
        supply_disrupt <= 1'b0;
        repeat (6) @(posedge mclk);
        check("offhook released", line_offhook, 32'h0);
        wr(lc2_addr, 8'h05);
        rd_chk("tone flag kept", lc2_addr, 32'h05);
        wr(lc2_addr, 8'h00);
        rd_chk("tone flag cleared", lc2_addr, 32'h0);
        $display("test tone detect done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
